// ==== src/sync_serial_port_8bit.sv ====
/*
  Top of the 8-bit synchronous serial port with its APB register slave.
  Assumes an APB master on CORE_CLK, and pins that arrive asynchronously;
  pin levels pass a two-stage synchroniser before any logic reads them.
*/
// The APB register port was decided locally.
`timescale 1ns/10ps

// Overview of operation
// - Software fills both buffers and then sets the enable bit, which starts a transfer.
// - At the start both buffers are copied into the internal 8-bit shift register.
// - At the start the ready output goes low to invite the far party to clock.
// - Each falling transfer clock edge drives the next bit out; each rising edge samples in.
// - After eight bits ready returns high, before the buffers and flags are updated.
// - On completion the received byte is written into both buffers.
// - On completion enable clears, the done flag sets and the serial interrupt status bit sets; IRQ rises only if that bit is unmasked.
// - The done flag is read-only and any access to the control register clears it.
// - Writing zero to enable during a transfer aborts it with no interrupt.
// - The bit-order select at zero sends most significant first, at one least first.
// - The clock select at zero drives the internal clock out, at one takes the pin clock in.
// - The lower buffer holds bits 0 to 3 and the upper buffer holds bits 4 to 7.
// - Reset clears order, clock select, done and enable, leaving an idle port.
// - With its pin function enabled the ready pin is always driven as an output.
// - With its pin function enabled the clock pin drives with internal clock, else listens.
module sync_serial_port_8bit #(
  parameter int CLK_HALF = ssp_pkg::SCLK_HALF_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SERIAL_DATA_IN,
  output logic             SERIAL_DATA_OUT,
  output logic             READY_OUT,
  output logic             READY_OE,
  input  wire logic        XFER_CLK_I,
  output logic             XFER_CLK_O,
  output logic             XFER_CLK_OE,
  output logic             IRQ
);

  // ==========================================================================
  // Declarations.
  logic                 pready_q;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;
  logic [3:0]           buf_lo_q;
  logic [3:0]           buf_hi_q;
  ssp_pkg::ctrl_t       ctrl_q;
  ssp_pkg::pincfg_t     pincfg_q;
  logic [3:0]           mask_q;
  logic [3:0]           status_q;
  logic                 irq_q;
  ssp_pkg::xfer_state_t state_q;
  ssp_pkg::xfer_state_t state_d;
  logic [7:0]           shift_q;
  logic [2:0]           bit_cnt_q;
  logic                 ready_q;
  logic                 ready_oe_q;
  logic                 clk_oe_q;
  logic                 sdo_q;
  logic                 sclk_q;
  logic [7:0]           div_q;
  logic [1:0]           pins_s;
  logic                 ext_clk_prev_q;
  logic                 access;
  logic                 wr_en;
  logic                 rd_en;
  logic [5:0]           idx;
  logic                 hit_lo;
  logic                 hit_hi;
  logic                 hit_ctrl;
  logic                 hit_pin;
  logic                 hit_ie;
  logic                 hit_irq;
  logic                 mapped;
  logic                 start;
  logic                 abort;
  logic                 busy;
  logic                 div_tick;
  logic                 ext_fall;
  logic                 ext_rise;
  logic                 fall_ev;
  logic                 rise_ev;
  logic                 last_rise;
  logic                 finish;
  logic [31:0]          rd_mux;

  // ==========================================================================
  // Pin synchronisers.
  ssp_sync2 #(
    .W (2)
  ) u_pin_sync (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .d   ({XFER_CLK_I, SERIAL_DATA_IN}),
    .q   (pins_s)
  );

  // ==========================================================================
  // APB decode.
  assign idx      = PADDR[7:2];
  assign hit_lo   = (idx == ssp_pkg::IDX_BUF_LO);
  assign hit_hi   = (idx == ssp_pkg::IDX_BUF_HI);
  assign hit_ctrl = (idx == ssp_pkg::IDX_CTRL);
  assign hit_pin  = (idx == ssp_pkg::IDX_PINCFG);
  assign hit_ie   = (idx == ssp_pkg::IDX_IE);
  assign hit_irq  = (idx == ssp_pkg::IDX_IRQ);
  assign mapped   = hit_lo | hit_hi | hit_ctrl | hit_pin | hit_ie | hit_irq;
  assign access   = PSEL & PENABLE & pready_q;
  assign wr_en    = access & PWRITE;
  assign rd_en    = access & ~PWRITE;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_lo) begin
      rd_mux[3:0] = buf_lo_q;
    end else if (hit_hi) begin
      rd_mux[3:0] = buf_hi_q;
    end else if (hit_ctrl) begin
      rd_mux[3:0] = ctrl_q;
    end else if (hit_pin) begin
      rd_mux[1:0] = pincfg_q;
    end else if (hit_ie) begin
      rd_mux[3:0] = mask_q;
    end else if (hit_irq) begin
      rd_mux[3:0] = status_q;
    end
  end

  // Read data is caught in the setup cycle so the slave answers with one wait-free access.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= PSEL & ~PENABLE;
      if (PSEL & ~PENABLE) begin
        prdata_q  <= PWRITE ? 32'h0000_0000 : rd_mux;
        pslverr_q <= ~mapped;
      end else if (access) begin
        prdata_q  <= 32'h0000_0000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Transfer control.
  assign busy     = (state_q == ssp_pkg::ST_SHIFT);
  assign start    = wr_en & hit_ctrl & PWDATA[ssp_pkg::CTRL_ENABLE_BIT]
                    & (state_q == ssp_pkg::ST_IDLE);
  assign abort    = wr_en & hit_ctrl & ~PWDATA[ssp_pkg::CTRL_ENABLE_BIT] & busy;
  assign finish   = (state_q == ssp_pkg::ST_FINISH);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ssp_pkg::ST_IDLE: begin
        if (start) begin
          state_d = ssp_pkg::ST_SHIFT;
        end
      end
      ssp_pkg::ST_SHIFT: begin
        if (abort) begin
          state_d = ssp_pkg::ST_IDLE;
        end else if (last_rise) begin
          state_d = ssp_pkg::ST_FINISH;
        end
      end
      ssp_pkg::ST_FINISH: begin
        state_d = ssp_pkg::ST_IDLE;
      end
      default: begin
        state_d = ssp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_q <= ssp_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Transfer clock: internal divider or edges found on the synchronised pin.
  assign div_tick = busy & ~ctrl_q.ext_clk & (div_q == 8'(CLK_HALF - 1));
  assign ext_fall = ext_clk_prev_q & ~pins_s[1];
  assign ext_rise = ~ext_clk_prev_q & pins_s[1];
  assign fall_ev  = busy & (ctrl_q.ext_clk ? ext_fall : (div_tick & sclk_q));
  assign rise_ev  = busy & (ctrl_q.ext_clk ? ext_rise : (div_tick & ~sclk_q));
  assign last_rise = rise_ev & (bit_cnt_q == ssp_pkg::LAST_BIT);

  // The internal clock idles high so that the first edge of a transfer is a fall.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      div_q  <= 8'h00;
      sclk_q <= 1'b1;
    end else if (busy & ~ctrl_q.ext_clk) begin
      if (div_tick) begin
        div_q  <= 8'h00;
        sclk_q <= ~sclk_q;
      end else begin
        div_q  <= div_q + 8'h01;
      end
    end else begin
      div_q  <= 8'h00;
      sclk_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ext_clk_prev_q <= 1'b1;
    end else begin
      ext_clk_prev_q <= pins_s[1];
    end
  end

  // ==========================================================================
  // Shift register and data output.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      shift_q   <= 8'h00;
      bit_cnt_q <= 3'h0;
    end else if (start) begin
      shift_q   <= {buf_hi_q, buf_lo_q};
      bit_cnt_q <= 3'h0;
    end else if (rise_ev) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (ctrl_q.order) begin
        shift_q <= {pins_s[0], shift_q[7:1]};
      end else begin
        shift_q <= {shift_q[6:0], pins_s[0]};
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sdo_q <= 1'b1;
    end else if (fall_ev) begin
      sdo_q <= ctrl_q.order ? shift_q[0] : shift_q[7];
    end
  end

  // ==========================================================================
  // Ready output and pin directions.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ready_q <= 1'b1;
    end else if (start) begin
      ready_q <= 1'b0;
    end else if (last_rise | abort) begin
      ready_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ready_oe_q <= 1'b0;
      clk_oe_q   <= 1'b0;
    end else begin
      ready_oe_q <= pincfg_q.ready_pin_en;
      clk_oe_q   <= pincfg_q.clk_pin_en & ~ctrl_q.ext_clk;
    end
  end

  // ==========================================================================
  // Registers.
  // Buffers take the received byte one cycle after ready rises.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      buf_lo_q <= ssp_pkg::RST_BUF;
      buf_hi_q <= ssp_pkg::RST_BUF;
    end else if (finish) begin
      buf_lo_q <= shift_q[3:0];
      buf_hi_q <= shift_q[7:4];
    end else if (wr_en) begin
      if (hit_lo) begin
        buf_lo_q <= PWDATA[3:0];
      end
      if (hit_hi) begin
        buf_hi_q <= PWDATA[3:0];
      end
    end
  end

  // A write of one to enable while busy starts nothing; order and clock select still load, and the running transfer goes on.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl_q <= ssp_pkg::RST_CTRL;
    end else begin
      if (wr_en & hit_ctrl) begin
        ctrl_q.order   <= PWDATA[ssp_pkg::CTRL_ORDER_BIT];
        ctrl_q.ext_clk <= PWDATA[ssp_pkg::CTRL_EXTCLK_BIT];
      end
      if (finish) begin
        ctrl_q.enable <= 1'b0;
      end else if (start) begin
        ctrl_q.enable <= 1'b1;
      end else if (abort) begin
        ctrl_q.enable <= 1'b0;
      end
      if (finish) begin
        ctrl_q.done <= 1'b1;
      end else if (access & hit_ctrl) begin
        ctrl_q.done <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pincfg_q <= ssp_pkg::RST_PINCFG;
      mask_q   <= ssp_pkg::RST_MASK;
    end else if (wr_en) begin
      if (hit_pin) begin
        pincfg_q <= PWDATA[1:0];
      end
      if (hit_ie) begin
        mask_q <= PWDATA[3:0];
      end
    end
  end

  // ==========================================================================
  // Interrupt status: sticky, cleared by a read, and a new event wins over the clear.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      status_q <= ssp_pkg::RST_STATUS;
    end else begin
      if (rd_en & hit_irq) begin
        status_q <= ssp_pkg::RST_STATUS;
      end
      if (finish) begin
        status_q[ssp_pkg::IRQ_SERIAL_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // ==========================================================================
  // Outputs.
  assign PRDATA          = prdata_q;
  assign PREADY          = pready_q;
  assign PSLVERR         = pslverr_q;
  assign SERIAL_DATA_OUT = sdo_q;
  assign READY_OUT       = ready_q;
  assign READY_OE        = ready_oe_q;
  assign XFER_CLK_O      = sclk_q;
  assign XFER_CLK_OE     = clk_oe_q;
  assign IRQ             = irq_q;

endmodule

// ==== shared/ssp_pkg.sv ====
/*
  Shared constants and types of the 8-bit synchronous serial port.
  Assumes an APB slave with 32-bit data; register indices are word indices,
  so the byte address of a register is four times its index.
*/
package ssp_pkg;

  // ==========================================================================
  // Register indices (byte address = 4 * index).
  localparam logic [5:0] IDX_BUF_LO = 6'h06;
  localparam logic [5:0] IDX_BUF_HI = 6'h07;
  localparam logic [5:0] IDX_CTRL   = 6'h08;
  localparam logic [5:0] IDX_PINCFG = 6'h09;
  localparam logic [5:0] IDX_IE     = 6'h30;
  localparam logic [5:0] IDX_IRQ    = 6'h34;

  // ==========================================================================
  // Field positions.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DONE_BIT   = 1;
  localparam int CTRL_EXTCLK_BIT = 2;
  localparam int CTRL_ORDER_BIT  = 3;
  localparam int IRQ_SERIAL_BIT  = 0;

  // ==========================================================================
  // Values after reset.
  localparam logic [3:0] RST_BUF    = 4'h0;
  localparam logic [3:0] RST_CTRL   = 4'h0;
  localparam logic [3:0] RST_MASK   = 4'h0;
  localparam logic [3:0] RST_STATUS = 4'h0;
  localparam logic [1:0] RST_PINCFG = 2'h0;

  // ==========================================================================
  // Counts.
  localparam int         SCLK_HALF_CYC = 4;
  localparam int         XFER_BITS     = 8;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam logic [11:0] SERIAL_VECTOR = 12'h035;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SHIFT  = 2'h1,
    ST_FINISH = 2'h3
  } xfer_state_t;

  typedef struct packed {
    logic order;
    logic ext_clk;
    logic done;
    logic enable;
  } ctrl_t;

  typedef struct packed {
    logic clk_pin_en;
    logic ready_pin_en;
  } pincfg_t;

endpackage

// ==== src/ssp_sync2.sv ====
/*
  Two flip-flop synchroniser for levels entering the core clock domain.
  Assumes each bit is an independent level; no multi-bit coherence.
*/
`timescale 1ns/10ps

module ssp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==========================================================================
  // Stages.
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ==== verification/ssp_checker_properties.sv ====
/* Checker of the serial port as seen at its pins.
   Assumes the clock pin level, whoever drives it, reaches XFER_CLK_I. */
`timescale 1ns/10ps

module ssp_checker #(
  parameter int CLK_HALF = 4
) (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        SERIAL_DATA_OUT,
  input wire logic        READY_OUT,
  input wire logic        XFER_CLK_I,
  input wire logic        XFER_CLK_O,
  input wire logic        XFER_CLK_OE,
  input wire logic        IRQ
);
  // ====================
  // Bus decoding and per-transfer bookkeeping.
  logic       commit;
  logic       ctrl_wr;
  logic       mask_q;
  logic       abort_q;
  logic [3:0] rise_q;
  assign commit  = PSEL && PENABLE && PREADY;
  assign ctrl_wr = commit && PWRITE && PADDR == 8'h20;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mask_q <= 1'h0;
    end else if (commit && PWRITE && PADDR == 8'hC0) begin
      mask_q <= PWDATA[0];
    end
  end
  // Pin rises are counted per frame, so a divider that stalls shows as a short count.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || $fell(READY_OUT)) begin
      rise_q  <= 4'h0;
      abort_q <= 1'h0;
    end else begin
      // The last internal rise lands with ready's own rise, so the level before the edge counts.
      if (!$past(READY_OUT) && $rose(XFER_CLK_I)) begin
        rise_q <= rise_q + 4'h1;
      end
      if (ctrl_wr && !PWDATA[0] && !READY_OUT) begin
        abort_q <= 1'h1;
      end
    end
  end
  // ====================
  // Properties.
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_start; ctrl_wr && PWDATA[0] && READY_OUT && $past(READY_OUT); endsequence
  sequence s_abort; ctrl_wr && !PWDATA[0] && !READY_OUT; endsequence
  sequence s_finish; $rose(READY_OUT) && !abort_q; endsequence
  property p_start; s_start |=> !READY_OUT; endproperty
  a_start: assert property (p_start)
    else $error("Ready stayed high after a start");
  property p_eight; s_finish |=> rise_q == 4'h8; endproperty
  a_eight: assert property (p_eight)
    else $error("Ready rose without eight clock rises");
  property p_done_irq; s_finish ##0 mask_q |-> ##[1:3] IRQ; endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("No interrupt after a completed frame");
  property p_read_clear; commit && !PWRITE && PADDR == 8'hD0 |-> ##2 !IRQ; endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("Interrupt stayed up after a status read");
  property p_abort; s_abort |=> READY_OUT; endproperty
  a_abort: assert property (p_abort)
    else $error("Ready stayed low after an abort");
  property p_abort_quiet; s_abort ##0 !IRQ |=> !IRQ [*8]; endproperty
  a_abort_quiet: assert property (p_abort_quiet)
    else $error("Interrupt after an aborted frame");
  property p_half;
    $rose(XFER_CLK_O) && !READY_OUT |->
      !$past(XFER_CLK_O, CLK_HALF) && $past(XFER_CLK_O, CLK_HALF + 1);
  endproperty
  a_half: assert property (p_half)
    else $error("Internal clock low phase has the wrong length");
  property p_out_fall;
    $changed(SERIAL_DATA_OUT) && XFER_CLK_OE |-> $fell(XFER_CLK_O);
  endproperty
  a_out_fall: assert property (p_out_fall)
    else $error("Data output moved without a clock fall");
endmodule

bind sync_serial_port_8bit ssp_checker #(.CLK_HALF(CLK_HALF)) u_chk (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .READY_OUT(READY_OUT), .XFER_CLK_I(XFER_CLK_I), .XFER_CLK_O(XFER_CLK_O),
  .XFER_CLK_OE(XFER_CLK_OE), .IRQ(IRQ)
);

// ==== verification/ssp_far_end.sv ====
/* Far-end model of the serial link, a controller that may supply the clock.
   Assumes the bench resolves the clock pin level and feeds it back as sclk_pin. */
`timescale 1ns/10ps

module ssp_far_end #(
  parameter int LEAD_NS = 313
) (
  input  wire logic       ext_mode,
  input  wire logic       lsb_first,
  input  wire logic       ready_out,
  input  wire logic       sclk_pin,
  input  wire logic       data_from_dev,
  input  wire logic [7:0] send_byte,
  output logic            sclk_drive,
  output logic            data_to_dev,
  output logic [7:0]      got_byte
);
  int n = 0;
  int m = 0;
  initial begin
    sclk_drive  = 1'h1;
    data_to_dev = 1'h1;
    got_byte    = 8'h00;
  end
  // ====================
  // The low phase is the longer one, so output data settles before the next rise.
  always @(negedge ready_out) begin
    n = 0;
    m = 0;
    if (ext_mode) begin
      #LEAD_NS;
      repeat (8) begin
        sclk_drive = 1'h0;
        #250;
        sclk_drive = 1'h1;
        #150;
      end
    end
  end
  always @(negedge sclk_pin) begin
    if (!ready_out) begin
      data_to_dev = send_byte[lsb_first ? n : 7 - n];
      n = n + 1;
    end
  end
  // A rise is taken only after its own fall, since the last internal rise comes with ready high.
  always @(posedge sclk_pin) begin
    if (m < n) begin
      got_byte = lsb_first ? {data_from_dev, got_byte[7:1]}
                           : {got_byte[6:0], data_from_dev};
      m = m + 1;
    end
  end
  // A released data line shows the inverse of its last bit, never a held copy.
  always @(posedge ready_out) data_to_dev = ~data_to_dev;
  // Stray pulses outside a frame, only when a test asks for them.
  task automatic stray(input int cnt);
    repeat (cnt) begin
      #263 sclk_drive = 1'h0;
      #263 sclk_drive = 1'h1;
    end
  endtask
endmodule

// ==== verification/sync_serial_port_8bit_test.sv ====
/* Self-checking bench of the 8-bit serial port.
   Assumes the far-end model and the checker bound to the port's top. */
`timescale 1ns/10ps

module sync_serial_port_8bit_test;
  logic        clk;
  logic        rst = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sdo;
  logic        sdi;
  logic        rdy;
  logic        rdy_oe;
  logic        clk_o;
  logic        clk_oe;
  logic        far_clk;
  logic        pin_clk;
  logic        irq;
  logic        far_ext = 1'h0;
  logic        far_lsb = 1'h0;
  logic [7:0]  far_tx = 8'h00;
  logic [7:0]  far_got;
  logic [31:0] rd;
  logic        err;
  logic [5:0]  regs [5] = '{ssp_pkg::IDX_BUF_LO, ssp_pkg::IDX_BUF_HI, ssp_pkg::IDX_CTRL,
                            ssp_pkg::IDX_IE, ssp_pkg::IDX_IRQ};
  logic [7:0]  tx_tab [4] = '{8'hA5, 8'h3C, 8'h81, 8'h6E};
  logic [7:0]  rx_tab [4] = '{8'h5A, 8'hC3, 8'h17, 8'hE8};
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  assign pin_clk = clk_oe ? clk_o : far_clk;
  sync_serial_port_8bit #(.CLK_HALF(4)) u_dut (
    .CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo), .READY_OUT(rdy), .READY_OE(rdy_oe),
    .XFER_CLK_I(pin_clk), .XFER_CLK_O(clk_o), .XFER_CLK_OE(clk_oe), .IRQ(irq)
  );
  ssp_far_end u_far (
    .ext_mode(far_ext), .lsb_first(far_lsb), .ready_out(rdy), .sclk_pin(pin_clk),
    .data_from_dev(sdo), .send_byte(far_tx), .sclk_drive(far_clk), .data_to_dev(sdi),
    .got_byte(far_got)
  );
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // ====================
  // Compares, bus cycles and the verdict.
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    chk_bit(pready, 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [3:0] v);
    apb(1'h1, idx, {28'h0, v});
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [3:0] v);
    apb(1'h0, idx, 32'h0);
    chk_val(rd, {28'h0, v});
    chk_bit(err, 1'h0);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One whole frame, checked from both ends of the link.
  task automatic xfer(input logic [3:0] ctl, input logic [7:0] tx, input logic [7:0] rx,
                      input logic m);
    int n;
    n = 0;
    far_ext <= ctl[2];
    far_lsb <= ctl[3];
    far_tx  <= rx;
    wr(ssp_pkg::IDX_IE, {3'h0, m});
    wr(ssp_pkg::IDX_BUF_LO, tx[3:0]);
    wr(ssp_pkg::IDX_BUF_HI, tx[7:4]);
    wr(ssp_pkg::IDX_CTRL, ctl);
    #1 chk_bit(rdy, 1'h0);
    while (rdy !== 1'h1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk_bit(rdy, 1'h1);
    chk_val({24'h0, far_got}, {24'h0, tx});
    chk_bit(clk_oe, !ctl[2]);
    repeat (4) @(posedge clk);
    chk_bit(irq, m);
    rd_chk(ssp_pkg::IDX_IRQ, 4'h1);
    rd_chk(ssp_pkg::IDX_IRQ, 4'h0);
    rd_chk(ssp_pkg::IDX_BUF_LO, rx[3:0]);
    rd_chk(ssp_pkg::IDX_BUF_HI, rx[7:4]);
    rd_chk(ssp_pkg::IDX_CTRL, {ctl[3:2], 2'h2});
    rd_chk(ssp_pkg::IDX_CTRL, {ctl[3:2], 2'h0});
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      print_verdict();
    end
  end
  // ====================
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      rd_chk(regs[i], 4'h0);
    end
    chk_bit(rdy, 1'h1);
    apb(1'h0, 6'h3F, 32'h0);
    chk_bit(err, 1'h1);
    chk_val(rd, 32'h0);
    wr(ssp_pkg::IDX_PINCFG, 4'h3);
    repeat (2) @(posedge clk);
    #1 chk_bit(rdy_oe, 1'h1);
    chk_bit(clk_oe, 1'h1);
    for (int i = 0; i < 4; i++) begin
      xfer({i[1], i[0], 2'h1}, tx_tab[i], rx_tab[i], i != 2);
    end
    far_ext <= 1'h0;
    wr(ssp_pkg::IDX_IE, 4'h1);
    wr(ssp_pkg::IDX_CTRL, 4'h1);
    repeat (20) @(posedge clk);
    wr(ssp_pkg::IDX_CTRL, 4'h0);
    #1 chk_bit(rdy, 1'h1);
    repeat (100) @(posedge clk);
    chk_bit(irq, 1'h0);
    rd_chk(ssp_pkg::IDX_IRQ, 4'h0);
    rd_chk(ssp_pkg::IDX_CTRL, 4'h0);
    wr(ssp_pkg::IDX_CTRL, 4'h4);
    wr(ssp_pkg::IDX_BUF_LO, 4'h9);
    wr(ssp_pkg::IDX_BUF_HI, 4'h6);
    u_far.stray(8);
    rd_chk(ssp_pkg::IDX_BUF_LO, 4'h9);
    rd_chk(ssp_pkg::IDX_BUF_HI, 4'h6);
    rd_chk(ssp_pkg::IDX_IRQ, 4'h0);
    rd_chk(ssp_pkg::IDX_CTRL, 4'h4);
    print_verdict();
  end
endmodule
